// File: inc/trs_pkg.sv
// constants, register map and state type of the trigger readout sequencer
package trs_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned L1_TIMEOUT_NS = 6000;
  localparam int unsigned L1_TIMEOUT_CYC = L1_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [10:0] L1_LAST = 11'(L1_TIMEOUT_CYC - 1);
  // topology
  localparam int NUM_CARDS = 3;
  localparam int NUM_HALF_STAVES = 6;
  localparam logic [1:0] LAST_CARD = 2'h2;
  // receiver card memory
  localparam int CARD_AW = 16;
  localparam logic [15:0] PTR_START_ADDR = 16'hFFFE;
  localparam logic [15:0] PTR_END_ADDR = 16'hFFFF;
  // header word group
  localparam logic [15:0] HDR_MARK = 16'hE5A1;
  localparam logic HDR_LAST = 1'h1;
  // spy memory
  localparam int SPY_AW = 15;
  localparam int SPY_DW = 36;
  localparam int SPY_DEPTH = 32768;
  // register offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_MASK = 12'h008;
  localparam logic [11:0] OFF_SPY_RADDR = 12'h00C;
  localparam logic [11:0] OFF_SPY_DATA = 12'h010;
  localparam logic [11:0] OFF_SPY_TAG = 12'h014;
  localparam logic [11:0] OFF_SPY_WPTR = 12'h018;
  localparam logic [11:0] OFF_TRIG_ID = 12'h01C;
  // control fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam logic [0:0] CTRL_RST = 1'h1;
  localparam logic [7:0] MASK_RST = 8'h00;
  // status fields
  localparam int STATUS_W = 8;
  localparam int ST_L1_TIMEOUT = 0;
  localparam int ST_SYNC_ERR = 1;
  localparam int ST_PROTO_ERR = 2;
  localparam int ST_EV_DONE = 3;
  localparam int ST_REJ_DONE = 4;
  localparam int ST_SKIP_LSB = 5;
  localparam logic [7:0] STATUS_KEEP = 8'h01;
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_L1, S_WAIT_L2, S_HDR, S_CHECK, S_RD_START, S_RD_END,
    S_PTR_A, S_PTR_B, S_RD_DATA, S_RD_GAP, S_RD_WORD, S_FLUSH, S_NEXT
  } trs_state_t;
endpackage

// File: inc/trs_spy_if.sv
// interface between the sequencer and its spy memory
`timescale 1ns/1ps
interface trs_spy_if;
  logic wr_en;
  logic [14:0] wr_addr;
  logic [35:0] wr_data;
  logic [14:0] rd_addr;
  logic [35:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// File: verilog/trs_spy_ram.sv
// spy memory: dual-port ram with a two-stage registered read
`timescale 1ns/1ps
module trs_spy_ram (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // ports
  trs_spy_if.mem spy
);
  logic [35:0] mem_ff [trs_pkg::SPY_DEPTH];
  logic [35:0] stage_ff;
  logic [35:0] rd_ff;

  // storage stays unreset; only the read pipeline has a defined start value
  always_ff @(posedge mclk)
  begin
    if (spy.wr_en)
    begin
      mem_ff[spy.wr_addr] <= spy.wr_data;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage_ff <= 36'h0;
      rd_ff <= 36'h0;
    end
    else
    begin
      stage_ff <= mem_ff[spy.rd_addr];
      rd_ff <= stage_ff;
    end
  end

  assign spy.rd_data = rd_ff;
endmodule

// File: verilog/trs_seq.sv
// trigger readout sequencer: trigger protocol, card readout, merge and spy copy
`timescale 1ns/1ps
module trs_seq (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger pins
  input wire logic trigger_level_zero,
  input wire logic trigger_level_one,
  input wire logic level_two_accept,
  input wire logic level_two_reject,
  // link receiver cards
  input wire logic [2:0] card_event_ready,
  input wire logic [2:0] card_link_ready,
  input wire logic [2:0] card_error,
  input wire logic [31:0] card_rdata,
  output logic card_rd,
  output logic [1:0] card_sel,
  output logic [15:0] card_addr,
  output logic [2:0] card_flush,
  // acquisition data link
  input wire logic link_ready,
  output logic [31:0] link_data,
  output logic link_header,
  output logic link_valid,
  // status pins
  output logic l1_error,
  output logic irq
);
  trs_spy_if spy ();

  trs_spy_ram u_spy (
    .mclk(mclk),
    .arst_n(arst_n),
    .spy(spy.mem)
  );

  // pin synchronisers: L0, L1, accept, reject / ready, link, error per card
  logic [3:0] trig_s1_ff, trig_s2_ff, trig_prev_ff;
  logic [8:0] card_s1_ff, card_s2_ff;
  logic l0_edge, l1_edge, acc_edge, rej_edge;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trig_s1_ff <= 4'h0;
      trig_s2_ff <= 4'h0;
      trig_prev_ff <= 4'h0;
      card_s1_ff <= 9'h000;
      card_s2_ff <= 9'h000;
    end
    else
    begin
      trig_s1_ff <= {level_two_reject, level_two_accept, trigger_level_one, trigger_level_zero};
      trig_s2_ff <= trig_s1_ff;
      trig_prev_ff <= trig_s2_ff;
      card_s1_ff <= {card_error, card_link_ready, card_event_ready};
      card_s2_ff <= card_s1_ff;
    end
  end

  assign l0_edge = trig_s2_ff[0] & ~trig_prev_ff[0];
  assign l1_edge = trig_s2_ff[1] & ~trig_prev_ff[1];
  assign acc_edge = trig_s2_ff[2] & ~trig_prev_ff[2];
  assign rej_edge = trig_s2_ff[3] & ~trig_prev_ff[3];

  // sequencer state
  trs_pkg::trs_state_t state_ff, nxt_state;
  logic [1:0] card_idx_ff, nxt_card_idx;
  logic [10:0] timer_ff, nxt_timer;
  logic hdr_idx_ff, nxt_hdr_idx;
  logic [15:0] cur_ff, nxt_cur, end_ff, nxt_end, trig_id_ff, nxt_trig_id;
  logic [15:0] ref_ff, nxt_ref;
  logic ref_valid_ff, nxt_ref_valid, first_ff, nxt_first;
  logic card_rd_ff, nxt_card_rd;
  logic [15:0] card_addr_ff, nxt_card_addr;
  logic [2:0] card_flush_ff, nxt_card_flush;
  logic [31:0] link_data_ff, nxt_link_data;
  logic link_hdr_ff, nxt_link_hdr, link_valid_ff, nxt_link_valid;
  logic [14:0] spy_wptr_ff, nxt_spy_wptr;
  logic [0:0] ctrl_ff;
  logic [7:0] status_ff;
  // events and word load
  logic ev_l1_to, ev_sync, ev_proto, ev_done, ev_rej;
  logic [2:0] ev_skip;
  logic load, load_hdr;
  logic [31:0] load_word;
  logic card_ok, ev_mismatch;
  logic [2:0] card_onehot;

  assign card_onehot = 3'(3'b001 << card_idx_ff);
  assign card_ok = card_s2_ff[3 + card_idx_ff] & ~card_s2_ff[6 + card_idx_ff];
  // first word of a card event carries the event numbers of its two half-staves
  assign ev_mismatch = (card_rdata[15:0] != card_rdata[31:16]) ||
                       (ref_valid_ff && card_rdata[15:0] != ref_ff);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_card_idx = card_idx_ff;
    nxt_timer = timer_ff;
    nxt_hdr_idx = hdr_idx_ff;
    nxt_cur = cur_ff;
    nxt_end = end_ff;
    nxt_trig_id = trig_id_ff;
    nxt_ref = ref_ff;
    nxt_ref_valid = ref_valid_ff;
    nxt_first = first_ff;
    nxt_card_rd = 1'b0;
    nxt_card_addr = card_addr_ff;
    nxt_card_flush = 3'h0;
    nxt_link_data = link_data_ff;
    nxt_link_hdr = link_hdr_ff;
    nxt_link_valid = link_valid_ff;
    nxt_spy_wptr = spy_wptr_ff;
    ev_l1_to = 1'b0;
    ev_sync = 1'b0;
    ev_proto = 1'b0;
    ev_done = 1'b0;
    ev_rej = 1'b0;
    ev_skip = 3'h0;
    load = 1'b0;
    load_hdr = 1'b0;
    load_word = 32'h0;
    // the output word is the block buffer; it is held until the link takes it
    if (link_valid_ff && link_ready)
    begin
      nxt_link_valid = 1'b0;
    end
    case (state_ff)
      trs_pkg::S_IDLE:
      begin
        if (l0_edge && ctrl_ff[trs_pkg::CTRL_EN_BIT])
        begin
          nxt_state = trs_pkg::S_WAIT_L1;
          nxt_timer = 11'h000;
          nxt_trig_id = trig_id_ff + 16'h0001;
        end
        else if (l1_edge || acc_edge || rej_edge)
        begin
          ev_proto = 1'b1;
        end
      end
      trs_pkg::S_WAIT_L1:
      begin
        if (l1_edge)
        begin
          nxt_state = trs_pkg::S_WAIT_L2;
        end
        else if (timer_ff == trs_pkg::L1_LAST)
        begin
          ev_l1_to = 1'b1;
          nxt_state = trs_pkg::S_IDLE;
        end
        else
        begin
          nxt_timer = timer_ff + 11'h001;
        end
      end
      trs_pkg::S_WAIT_L2:
      begin
        // a reject seen with an accept wins, so no data leaves on a confused decision
        if (rej_edge)
        begin
          nxt_card_flush = 3'h7;
          ev_rej = 1'b1;
          nxt_state = trs_pkg::S_IDLE;
        end
        else if (acc_edge)
        begin
          nxt_state = trs_pkg::S_HDR;
          nxt_hdr_idx = 1'b0;
          nxt_card_idx = 2'h0;
          nxt_ref_valid = 1'b0;
        end
      end
      trs_pkg::S_HDR:
      begin
        if (!link_valid_ff)
        begin
          load = 1'b1;
          load_hdr = 1'b1;
          load_word = hdr_idx_ff ? {13'h0000, card_s2_ff[8:6], 13'h0000, card_s2_ff[5:3]}
                                 : {trs_pkg::HDR_MARK, trig_id_ff};
          nxt_hdr_idx = 1'b1;
          if (hdr_idx_ff == trs_pkg::HDR_LAST)
          begin
            nxt_state = trs_pkg::S_CHECK;
          end
        end
      end
      trs_pkg::S_CHECK:
      begin
        if (!card_ok)
        begin
          ev_skip = card_onehot;
          nxt_state = trs_pkg::S_NEXT;
        end
        else if (card_s2_ff[card_idx_ff])
        begin
          nxt_state = trs_pkg::S_RD_START;
        end
        else
        begin
          nxt_state = trs_pkg::S_NEXT;
        end
      end
      trs_pkg::S_RD_START:
      begin
        nxt_card_rd = 1'b1;
        nxt_card_addr = trs_pkg::PTR_START_ADDR;
        nxt_state = trs_pkg::S_RD_END;
      end
      trs_pkg::S_RD_END:
      begin
        nxt_card_rd = 1'b1;
        nxt_card_addr = trs_pkg::PTR_END_ADDR;
        nxt_state = trs_pkg::S_PTR_A;
      end
      trs_pkg::S_PTR_A:
      begin
        nxt_cur = card_rdata[15:0];
        nxt_state = trs_pkg::S_PTR_B;
      end
      trs_pkg::S_PTR_B:
      begin
        nxt_end = card_rdata[15:0];
        nxt_first = 1'b1;
        nxt_state = trs_pkg::S_RD_DATA;
      end
      trs_pkg::S_RD_DATA:
      begin
        if (cur_ff == end_ff)
        begin
          nxt_state = trs_pkg::S_FLUSH;
        end
        else if (!link_valid_ff)
        begin
          nxt_card_rd = 1'b1;
          nxt_card_addr = cur_ff;
          nxt_state = trs_pkg::S_RD_GAP;
        end
      end
      trs_pkg::S_RD_GAP:
      begin
        nxt_state = trs_pkg::S_RD_WORD;
      end
      trs_pkg::S_RD_WORD:
      begin
        nxt_cur = cur_ff + 16'h0001;
        nxt_first = 1'b0;
        nxt_state = trs_pkg::S_RD_DATA;
        if (first_ff && ev_mismatch)
        begin
          ev_sync = 1'b1;
          nxt_state = trs_pkg::S_FLUSH;
        end
        else
        begin
          load = 1'b1;
          load_word = card_rdata;
          if (first_ff && !ref_valid_ff)
          begin
            nxt_ref = card_rdata[15:0];
            nxt_ref_valid = 1'b1;
          end
        end
      end
      trs_pkg::S_FLUSH:
      begin
        nxt_card_flush = card_onehot;
        nxt_state = trs_pkg::S_NEXT;
      end
      trs_pkg::S_NEXT:
      begin
        if (card_idx_ff == trs_pkg::LAST_CARD)
        begin
          ev_done = 1'b1;
          nxt_state = trs_pkg::S_IDLE;
        end
        else
        begin
          nxt_card_idx = card_idx_ff + 2'h1;
          nxt_state = trs_pkg::S_CHECK;
        end
      end
      default:
      begin
        nxt_state = trs_pkg::S_IDLE;
      end
    endcase
    if (load)
    begin
      nxt_link_data = load_word;
      nxt_link_hdr = load_hdr;
      nxt_link_valid = 1'b1;
      nxt_spy_wptr = spy_wptr_ff + 15'h0001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= trs_pkg::S_IDLE;
      card_idx_ff <= 2'h0;
      timer_ff <= 11'h000;
      hdr_idx_ff <= 1'b0;
      cur_ff <= 16'h0000;
      end_ff <= 16'h0000;
      trig_id_ff <= 16'h0000;
      ref_ff <= 16'h0000;
      ref_valid_ff <= 1'b0;
      first_ff <= 1'b0;
      card_rd_ff <= 1'b0;
      card_addr_ff <= 16'h0000;
      card_flush_ff <= 3'h0;
      link_data_ff <= 32'h0;
      link_hdr_ff <= 1'b0;
      link_valid_ff <= 1'b0;
      spy_wptr_ff <= 15'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      card_idx_ff <= nxt_card_idx;
      timer_ff <= nxt_timer;
      hdr_idx_ff <= nxt_hdr_idx;
      cur_ff <= nxt_cur;
      end_ff <= nxt_end;
      trig_id_ff <= nxt_trig_id;
      ref_ff <= nxt_ref;
      ref_valid_ff <= nxt_ref_valid;
      first_ff <= nxt_first;
      card_rd_ff <= nxt_card_rd;
      card_addr_ff <= nxt_card_addr;
      card_flush_ff <= nxt_card_flush;
      link_data_ff <= nxt_link_data;
      link_hdr_ff <= nxt_link_hdr;
      link_valid_ff <= nxt_link_valid;
      spy_wptr_ff <= nxt_spy_wptr;
    end
  end

  // spy copy is written in the same cycle the word enters the link buffer
  assign spy.wr_en = load;
  assign spy.wr_addr = spy_wptr_ff;
  assign spy.wr_data = {3'h0, load_hdr, load_word};

  // apb register file; pready comes in the first cycle of the access phase
  logic [0:0] nxt_ctrl;
  logic [7:0] nxt_status, mask_ff, nxt_mask, set_vec, clr_vec;
  logic [14:0] spy_raddr_ff, nxt_spy_raddr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, irq_ff, nxt_irq;
  logic apb_setup, apb_wr;

  assign apb_setup = psel & ~penable & ~pready_ff;
  assign apb_wr = psel & penable & pready_ff & pwrite;
  assign set_vec = {ev_skip, ev_rej, ev_done, ev_proto, ev_sync, ev_l1_to};

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_spy_raddr = spy_raddr_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    nxt_pready = 1'b0;
    clr_vec = 8'h00;
    if (apb_setup)
    begin
      nxt_pready = 1'b1;
      nxt_pslverr = 1'b0;
      case (paddr)
        trs_pkg::OFF_CTRL: nxt_prdata = {31'h0, ctrl_ff};
        trs_pkg::OFF_STATUS: nxt_prdata = {24'h0, status_ff};
        trs_pkg::OFF_MASK: nxt_prdata = {24'h0, mask_ff};
        trs_pkg::OFF_SPY_RADDR: nxt_prdata = {17'h0, spy_raddr_ff};
        trs_pkg::OFF_SPY_DATA: nxt_prdata = spy.rd_data[31:0];
        trs_pkg::OFF_SPY_TAG: nxt_prdata = {28'h0, spy.rd_data[35:32]};
        trs_pkg::OFF_SPY_WPTR: nxt_prdata = {17'h0, spy_wptr_ff};
        trs_pkg::OFF_TRIG_ID: nxt_prdata = {16'h0, trig_id_ff};
        default:
        begin
          nxt_prdata = 32'h0;
          nxt_pslverr = 1'b1;
        end
      endcase
    end
    if (apb_wr)
    begin
      case (paddr)
        trs_pkg::OFF_CTRL: nxt_ctrl = pwdata[0:0];
        trs_pkg::OFF_STATUS: clr_vec = pwdata[7:0] & ~trs_pkg::STATUS_KEEP;
        trs_pkg::OFF_MASK: nxt_mask = pwdata[7:0];
        trs_pkg::OFF_SPY_RADDR: nxt_spy_raddr = pwdata[14:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    // a new event wins over a clear in the same cycle
    nxt_status = (status_ff & ~clr_vec) | set_vec;
    nxt_irq = |(status_ff & mask_ff);
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_ff <= trs_pkg::CTRL_RST;
      status_ff <= 8'h00;
      mask_ff <= trs_pkg::MASK_RST;
      spy_raddr_ff <= 15'h0000;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      spy_raddr_ff <= nxt_spy_raddr;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff <= nxt_irq;
    end
  end

  assign spy.rd_addr = spy_raddr_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign card_rd = card_rd_ff;
  assign card_sel = card_idx_ff;
  assign card_addr = card_addr_ff;
  assign card_flush = card_flush_ff;
  assign link_data = link_data_ff;
  assign link_header = link_hdr_ff;
  assign link_valid = link_valid_ff;
  assign l1_error = status_ff[trs_pkg::ST_L1_TIMEOUT];
  assign irq = irq_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  idle_start_a: assert property ((state_ff == trs_pkg::S_IDLE && l0_edge && ctrl_ff[0])
    |=> state_ff == trs_pkg::S_WAIT_L1 && timer_ff == 11'h000)
    else $error("level-0 not taken");
  l1_timeout_a: assert property ((state_ff == trs_pkg::S_WAIT_L1 && !l1_edge &&
    timer_ff == trs_pkg::L1_LAST) |=> status_ff[0] && l1_error ##1 status_ff[0])
    else $error("level-1 timeout missed");
  l1_sticky_a: assert property (status_ff[0] |=> status_ff[0])
    else $error("timeout error cleared");
  l2_wait_a: assert property ((state_ff == trs_pkg::S_WAIT_L1 && l1_edge)
    |=> state_ff == trs_pkg::S_WAIT_L2) else $error("level-2 wait not entered");
  card_order_a: assert property ((state_ff == trs_pkg::S_NEXT && card_idx_ff != trs_pkg::LAST_CARD)
    |=> card_idx_ff == $past(card_idx_ff) + 2'h1 && state_ff == trs_pkg::S_CHECK)
    else $error("card order broken");
  ptr_first_a: assert property ((state_ff == trs_pkg::S_RD_START) |=> card_rd_ff &&
    card_addr_ff == 16'hFFFE ##1 card_rd_ff && card_addr_ff == 16'hFFFF)
    else $error("pointers not read first");
  flush_after_a: assert property ((state_ff == trs_pkg::S_FLUSH)
    |=> card_flush_ff == $past(card_onehot)) else $error("flush missing after readout");
  reject_flush_a: assert property ((state_ff == trs_pkg::S_WAIT_L2 && rej_edge)
    |=> card_flush_ff == 3'h7 && !card_rd_ff ##1 !card_rd_ff && state_ff == trs_pkg::S_IDLE)
    else $error("reject handling wrong");
  spy_copy_a: assert property (spy.wr_en |=> link_valid_ff &&
    link_data_ff == $past(spy.wr_data[31:0]) && spy_wptr_ff == $past(spy_wptr_ff) + 15'h0001)
    else $error("spy copy mismatch");
  sync_err_a: assert property ((state_ff == trs_pkg::S_RD_WORD && first_ff && ev_mismatch)
    |=> status_ff[1] && state_ff == trs_pkg::S_FLUSH && !$changed(spy_wptr_ff))
    else $error("mismatch merged silently");
  skip_flag_a: assert property ((state_ff == trs_pkg::S_CHECK && !card_ok)
    |=> status_ff[5 + card_idx_ff] && state_ff == trs_pkg::S_NEXT)
    else $error("bad card not skipped");
  done_idle_a: assert property ((state_ff == trs_pkg::S_NEXT && card_idx_ff == trs_pkg::LAST_CARD)
    |=> state_ff == trs_pkg::S_IDLE && status_ff[3]) else $error("no return to idle");

  readout_c: cover property (state_ff == trs_pkg::S_RD_WORD && !ev_mismatch
    ##1 state_ff == trs_pkg::S_RD_DATA);
  reject_c: cover property (state_ff == trs_pkg::S_WAIT_L2 && rej_edge);
  timeout_c: cover property (state_ff == trs_pkg::S_WAIT_L1 ##1 status_ff[0]);
  sync_c: cover property (ev_sync);
endmodule

// File: test/trs_far_model.sv
// far side model: receiver card memories and a stalling acquisition link
`timescale 1ns/1ps
module trs_far_model (
  // clock
  input wire logic mclk,
  // card bus
  input wire logic card_rd,
  input wire logic [1:0] card_sel,
  input wire logic [15:0] card_addr,
  output logic [31:0] card_rdata,
  // link and fault control
  input wire logic slow,
  input wire logic [2:0] bad_card,
  output logic link_ready
);
  logic [15:0] ev = 16'h0007;
  initial card_rdata = 32'h00000000;
  initial link_ready = 1'b1;
  // each card holds one event at 0x10..0x11, end address exclusive
  always @(posedge mclk)
  begin
    link_ready <= slow ? ~link_ready : 1'b1;
    if (!card_rd)
      card_rdata <= ~card_rdata; // no stale data outside a read
    else if (card_addr == 16'hFFFE)
      card_rdata <= 32'h00000010;
    else if (card_addr == 16'hFFFF)
      card_rdata <= 32'h00000012;
    else if (card_addr == 16'h0010)
      card_rdata <= {ev + {15'h0000, bad_card[card_sel]}, ev};
    else
      card_rdata <= {14'h0000, card_sel, card_addr};
  end
endmodule

// File: test/trigger_readout_sequencer_tb.sv
// self-checking bench of the trigger readout sequencer
`timescale 1ns/1ps
module trigger_readout_sequencer_tb;
  logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, clr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, card_rdata, link_data, r, w0;
  logic pready, pslverr, card_rd, link_ready, link_header, link_valid, l1_error, irq, e, rds;
  logic [3:0] trg = 4'h0;
  logic [2:0] evr = 3'h0, lkr = 3'h7, cer = 3'h0, bad = 3'h0, card_flush, fls;
  logic [1:0] card_sel;
  logic [15:0] card_addr;
  int nhdr, bad_count, total_checks;
  always #2.5 mclk = ~mclk;
  trs_seq dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_level_zero(trg[0]), .trigger_level_one(trg[1]),
    .level_two_accept(trg[2]), .level_two_reject(trg[3]), .card_event_ready(evr),
    .card_link_ready(lkr), .card_error(cer), .card_rdata(card_rdata), .card_rd(card_rd),
    .card_sel(card_sel), .card_addr(card_addr), .card_flush(card_flush),
    .link_ready(link_ready), .link_data(link_data), .link_header(link_header),
    .link_valid(link_valid), .l1_error(l1_error), .irq(irq));
  trs_far_model far (.mclk(mclk), .card_rd(card_rd), .card_sel(card_sel),
    .card_addr(card_addr), .card_rdata(card_rdata), .slow(slow), .bad_card(bad),
    .link_ready(link_ready));
  always @(posedge mclk)
  begin
    fls <= clr ? 3'h0 : fls | card_flush;
    rds <= clr ? 1'b0 : rds | card_rd;
    if (clr)
      nhdr <= 0;
    else if (link_valid && link_ready && link_header)
    begin
      if (nhdr == 0)
        w0 <= link_data;
      nhdr <= nhdr + 1;
    end
  end
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      $display("[FAIL] %s expected %h seen %h", s, x, g);
      bad_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic pulse(input int i);
    trg[i] <= 1'b1;
    repeat (3) @(posedge mclk);
    trg[i] <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic wst(input logic [31:0] m);
    clr <= 1'b0;
    for (int i = 0; i < 80; i++)
    begin
      apb(0, trs_pkg::OFF_STATUS, 0);
      if ((r & m) != 0)
        break;
    end
  endtask
  // level-0, level-1 and one level-2 pin, with the history cleared first
  task automatic run(input int l2);
    clr <= 1'b1;
    @(posedge mclk);
    // history must record from here on, the decision acts while its pin is still high
    clr <= 1'b0;
    pulse(0);
    pulse(1);
    pulse(l2);
  endtask
  task automatic t_regs;
    apb(0, trs_pkg::OFF_CTRL, 0);
    chk("ctrl", 32'h1, r);
    apb(0, trs_pkg::OFF_MASK, 0);
    chk("mask", 32'h0, r);
    apb(0, 12'hFF0, 0);
    chk("unmapped", 32'h1, {31'h0, e});
  endtask
  task automatic t_accept;
    evr <= 3'h5;
    lkr <= 3'h5;
    slow <= 1'b1;
    run(2);
    wst(32'h08);
    chk("status", 32'h48, r);
    chk("flushes", 32'h5, {29'h0, fls});
    chk("reads", 32'h1, {31'h0, rds});
    chk("headers", 32'h2, nhdr);
    chk("hdr0", {trs_pkg::HDR_MARK, 16'h0001}, w0);
    apb(0, trs_pkg::OFF_TRIG_ID, 0);
    chk("trig id", 32'h1, r);
    apb(1, trs_pkg::OFF_SPY_RADDR, 0);
    repeat (3) @(posedge mclk);
    apb(0, trs_pkg::OFF_SPY_DATA, 0);
    chk("spy data", {trs_pkg::HDR_MARK, 16'h0001}, r);
    apb(0, trs_pkg::OFF_SPY_TAG, 0);
    chk("spy tag", 32'h1, r & 32'h1);
    apb(1, trs_pkg::OFF_STATUS, 32'hFF);
  endtask
  task automatic t_mismatch;
    evr <= 3'h7;
    lkr <= 3'h7;
    bad <= 3'h2;
    slow <= 1'b0;
    run(2);
    wst(32'h08);
    chk("sync err", 32'h2, r & 32'h2);
    chk("flushes", 32'h7, {29'h0, fls});
    apb(1, trs_pkg::OFF_STATUS, 32'hFF);
    bad <= 3'h0;
  endtask
  task automatic t_reject;
    run(3);
    wst(32'h10);
    chk("flushes", 32'h7, {29'h0, fls});
    chk("reads", 32'h0, {31'h0, rds});
    apb(1, trs_pkg::OFF_MASK, 32'h10);
    repeat (3) @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1, trs_pkg::OFF_STATUS, 32'h10);
    repeat (3) @(posedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    pulse(1);
    wst(32'h04);
    chk("proto err", 32'h4, r & 32'h4);
    apb(1, trs_pkg::OFF_STATUS, 32'hFF);
  endtask
  task automatic t_timeout;
    pulse(0);
    repeat (1100) @(posedge mclk);
    chk("l1 err", 32'h0, {31'h0, l1_error});
    repeat (150) @(posedge mclk);
    chk("l1 err", 32'h1, {31'h0, l1_error});
    apb(1, trs_pkg::OFF_STATUS, 32'hFF);
    pulse(0);
    apb(0, trs_pkg::OFF_STATUS, 0);
    chk("sticky", 32'h1, r & 32'h1);
    arst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk("l1 err", 32'h0, {31'h0, l1_error});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    summarize;
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_regs;
    t_accept;
    t_mismatch;
    t_reject;
    t_timeout;
    summarize;
  end
endmodule
